// ===== sdm_regs.vh
`ifndef SDM_REGS_VH
`define SDM_REGS_VH
// ******************************
// Register byte offsets
// ******************************
`define SDM_OFF_CTRL 8'h00
`define SDM_OFF_STAT 8'h04
`define SDM_OFF_IRQ_STAT 8'h08
`define SDM_OFF_IRQ_CLR 8'h0C
`define SDM_OFF_IRQ_EN 8'h10
`define SDM_OFF_WORD 8'h14
// ******************************
// Control fields
// ******************************
`define SDM_CTRL_PD_N 0
`define SDM_CTRL_MUTE_N 1
`define SDM_CTRL_CKMUTE_N 2
`define SDM_CTRL_REFSEL_N 3
`define SDM_CTRL_SDOUT_EN 4
`define SDM_CTRL_BCKOUT_EN 5
`define SDM_CTRL_SDMUTE 6
`define SDM_CTRL_RESET 8'h0F
// ******************************
// Status and event fields
// ******************************
`define SDM_EV_WORD 0
`define SDM_EV_ALOSS 1
`define SDM_EV_TLOSS 2
`define SDM_EV_W 3
// ******************************
// Timing
// ******************************
`define SDM_WORD_BITS 16
`define SDM_CNT_W 4
`define SDM_CNT_LAST 4'hF
`define SDM_CNT_HALF 4'h8
`define SDM_TLOSS_RUN 8'h40
`endif

// ===== sdm_sync.v
`timescale 1ns/1ps
// ******************************
// Two-stage level synchroniser
// ******************************
module sdm_sync (
  aclk,
  aresetn,
  ce,
  d,
  q
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire d;
  output reg q;
  reg meta_reg;
  // First stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ===== sdm_axil.v
`timescale 1ns/1ps
`include "sdm_regs.vh"
// ******************************
// AXI4-Lite slave front end
// ******************************
module sdm_axil (
  aclk,
  aresetn,
  ce,
  awaddr,
  awvalid,
  awready,
  wdata,
  wstrb,
  wvalid,
  wready,
  bresp,
  bvalid,
  bready,
  araddr,
  arvalid,
  arready,
  rdata,
  rresp,
  rvalid,
  rready,
  wr_en,
  wr_addr,
  wr_data,
  wr_strb0,
  rd_addr,
  rd_data,
  rd_hit,
  rd_en
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire [7:0] awaddr;
  input wire awvalid;
  output wire awready;
  input wire [31:0] wdata;
  input wire [3:0] wstrb;
  input wire wvalid;
  output wire wready;
  output reg [1:0] bresp;
  output reg bvalid;
  input wire bready;
  input wire [7:0] araddr;
  input wire arvalid;
  output wire arready;
  output reg [31:0] rdata;
  output reg [1:0] rresp;
  output reg rvalid;
  input wire rready;
  output wire wr_en;
  output wire [7:0] wr_addr;
  output wire [31:0] wr_data;
  output wire wr_strb0;
  output wire [7:0] rd_addr;
  input wire [31:0] rd_data;
  input wire rd_hit;
  output wire rd_en;
  reg aw_full_reg;
  reg w_full_reg;
  reg [7:0] aw_reg;
  reg [31:0] w_reg;
  reg w_strb_reg;
  // Each channel latched independently, so either may come first
  assign awready = ce && !aw_full_reg && !bvalid;
  assign wready = ce && !w_full_reg && !bvalid;
  assign wr_en = ce && aw_full_reg && w_full_reg && !bvalid;
  assign wr_addr = aw_reg;
  assign wr_data = w_reg;
  assign wr_strb0 = w_strb_reg;
  assign arready = ce && !rvalid;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;
  // Write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h00000000;
      w_strb_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        aw_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        w_reg <= wdata;
        w_strb_reg <= wstrb[0];
      end
      if (wr_en) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'h0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // Read path; unmapped reads answer SLVERR with zero data
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (ce) begin
      if (rd_en) begin
        rvalid <= 1'b1;
        rdata <= rd_hit ? rd_data : 32'h00000000;
        rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== sdm_top.v
`timescale 1ns/1ps
`include "sdm_regs.vh"
// Notes on behaviour
// - Serial bits are gathered into 16-bit parallel words at 1/16 rate.
// - Words align to a divided word clock, driven on word_clock_out.
// - Parity covers all 16 data bits, valid only while powered up.
// - Powerdown low floats data and parity outputs; high runs normally.
// - Data mute low mutes demux input data; high passes data.
// - Clock mute low holds word clock low, still driven.
// - Reference select low picks external clock as PLL reference.
// - Global reset low clears the word path; true outputs low, complements high.
// - Serial data and bit clock outputs can be disabled; data muted.
// - Separate flags report analog loss and transition loss.
// - Optional external reference clock used when selected and seen toggling.
// - First received bit lands on the most significant output bit.
// - Muting feeds zeros so outputs stay low; recovery is unaffected.
module sdm_top (
  aclk,
  aresetn,
  ce,
  global_reset_n,
  serial_bit,
  serial_bit_valid,
  amp_serial_in,
  logic_serial_in,
  serial_src_logic,
  ext_ref_clock,
  analog_signal_loss,
  word_out,
  word_out_n,
  word_out_oe,
  word_parity_out,
  word_parity_out_n,
  word_clock_out,
  word_clock_out_n,
  word_strobe,
  serial_data_out,
  serial_data_oe,
  bit_clock_out,
  bit_clock_oe,
  pll_ref_is_ext,
  transition_loss,
  awaddr,
  awvalid,
  awready,
  wdata,
  wstrb,
  wvalid,
  wready,
  bresp,
  bvalid,
  bready,
  araddr,
  arvalid,
  arready,
  rdata,
  rresp,
  rvalid,
  rready,
  irq
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire global_reset_n;
  input wire serial_bit;
  input wire serial_bit_valid;
  input wire amp_serial_in;
  input wire logic_serial_in;
  input wire serial_src_logic;
  input wire ext_ref_clock;
  input wire analog_signal_loss;
  output reg [15:0] word_out;
  output reg [15:0] word_out_n;
  output wire word_out_oe;
  output reg word_parity_out;
  output reg word_parity_out_n;
  output reg word_clock_out;
  output reg word_clock_out_n;
  output reg word_strobe;
  output reg serial_data_out;
  output wire serial_data_oe;
  output reg bit_clock_out;
  output wire bit_clock_oe;
  output wire pll_ref_is_ext;
  output wire transition_loss;
  input wire [7:0] awaddr;
  input wire awvalid;
  output wire awready;
  input wire [31:0] wdata;
  input wire [3:0] wstrb;
  input wire wvalid;
  output wire wready;
  output wire [1:0] bresp;
  output wire bvalid;
  input wire bready;
  input wire [7:0] araddr;
  input wire arvalid;
  output wire arready;
  output wire [31:0] rdata;
  output wire [1:0] rresp;
  output wire rvalid;
  input wire rready;
  output wire irq;

  // ******************************
  // Helpers
  // ******************************
  // Even parity: odd number of ones sets the bit
  function parity16;
    input [15:0] w;
    begin
      parity16 = ^w;
    end
  endfunction

  // Word clock is high for counts 15 and 0 to 6, so it rises with the word
  function wclk_high;
    input [`SDM_CNT_W-1:0] c;
    begin
      wclk_high = (c == `SDM_CNT_LAST) || (c < `SDM_CNT_HALF - 4'h1);
    end
  endfunction

  // ******************************
  // Pin synchronisers
  // ******************************
  wire gres_n_s;
  wire aloss_s;
  wire ref_s;
  sdm_sync u_sync_rst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .d(global_reset_n), .q(gres_n_s));
  sdm_sync u_sync_aloss (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .d(analog_signal_loss), .q(aloss_s));
  sdm_sync u_sync_ref (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .d(ext_ref_clock), .q(ref_s));

  // ******************************
  // Registers
  // ******************************
  reg [7:0] ctrl_reg;
  reg [`SDM_EV_W-1:0] ev_reg;
  reg [`SDM_EV_W-1:0] ev_en_reg;
  reg [`SDM_EV_W-1:0] ev_set;
  reg [`SDM_CNT_W-1:0] cnt_reg;
  reg [15:0] shift_reg;
  reg [7:0] tl_cnt_reg;
  reg last_bit_reg;
  reg ref_seen_reg;
  reg ref_prev_reg;
  reg aloss_prev_reg;
  reg tloss_prev_reg;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire wr_strb0;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_hit;
  wire rd_en;
  wire run;
  wire din;
  wire [15:0] word_next;

  assign run = aresetn && gres_n_s;
  // Mute forces zeros into the demux only; serial_bit feeds it directly
  assign din = ctrl_reg[`SDM_CTRL_MUTE_N] & serial_bit;
  // Oldest bit ends up at bit 15
  assign word_next = {shift_reg[14:0], din};
  assign word_out_oe = ctrl_reg[`SDM_CTRL_PD_N];
  assign serial_data_oe = ctrl_reg[`SDM_CTRL_SDOUT_EN];
  assign bit_clock_oe = ctrl_reg[`SDM_CTRL_BCKOUT_EN];
  // Reference pick; external clock only used once seen toggling
  assign pll_ref_is_ext = !ctrl_reg[`SDM_CTRL_REFSEL_N]
    && ref_seen_reg;
  assign transition_loss = (tl_cnt_reg == `SDM_TLOSS_RUN);
  assign irq = |(ev_reg & ev_en_reg);

  sdm_axil u_bus (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_strb0(wr_strb0), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_hit(rd_hit), .rd_en(rd_en));

  // ******************************
  // Word assembly and outputs
  // ******************************
  // Counter restarts whenever either reset is active
  always @(posedge aclk) begin
    if (!run) begin
      cnt_reg <= {`SDM_CNT_W{1'b0}};
      shift_reg <= 16'h0000;
      word_out <= 16'h0000;
      word_out_n <= 16'hFFFF;
      word_parity_out <= 1'b0;
      word_parity_out_n <= 1'b1;
      word_clock_out <= 1'b0;
      word_clock_out_n <= 1'b1;
      word_strobe <= 1'b0;
      serial_data_out <= 1'b0;
      bit_clock_out <= 1'b0;
    end else if (ce) begin
      word_strobe <= 1'b0;
      bit_clock_out <= serial_bit_valid;
      // Mute acts at once; waiting for the next bit could leave it high
      if (!ctrl_reg[`SDM_CTRL_CKMUTE_N]) begin
        word_clock_out <= 1'b0;
        word_clock_out_n <= 1'b1;
      end else if (serial_bit_valid) begin
        word_clock_out <= wclk_high(cnt_reg);
        word_clock_out_n <= !wclk_high(cnt_reg);
      end
      if (serial_bit_valid) begin
        // Loopback out ignores demux mute, obeys serial mute
        serial_data_out <= serial_bit
          & !ctrl_reg[`SDM_CTRL_SDMUTE];
        shift_reg <= word_next;
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == `SDM_CNT_LAST) begin
          // Powered down: hold outputs to save toggling
          if (ctrl_reg[`SDM_CTRL_PD_N]) begin
            word_out <= word_next;
            word_out_n <= ~word_next;
            word_parity_out <= parity16(word_next);
            word_parity_out_n <= ~parity16(word_next);
          end
          word_strobe <= 1'b1;
        end
      end
    end
  end

  // ******************************
  // Loss detection and reference watch
  // ******************************
  // Transitions counted on the raw retimed stream, unaffected by mute
  always @(posedge aclk) begin
    if (!run) begin
      tl_cnt_reg <= 8'h00;
      last_bit_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      ref_seen_reg <= 1'b0;
    end else if (ce) begin
      ref_prev_reg <= ref_s;
      if (ref_s != ref_prev_reg)
        ref_seen_reg <= 1'b1;
      if (serial_bit_valid) begin
        last_bit_reg <= serial_bit;
        if (serial_bit != last_bit_reg)
          tl_cnt_reg <= 8'h00;
        else if (tl_cnt_reg != `SDM_TLOSS_RUN)
          tl_cnt_reg <= tl_cnt_reg + 8'h01;
      end
    end
  end

  // ******************************
  // Register file and events
  // ******************************
  always @* begin
    ev_set = {`SDM_EV_W{1'b0}};
    ev_set[`SDM_EV_WORD] = word_strobe;
    ev_set[`SDM_EV_ALOSS] = aloss_s && !aloss_prev_reg;
    ev_set[`SDM_EV_TLOSS] = transition_loss && !tloss_prev_reg;
  end

  // Set beats clear in the same cycle so no event is lost
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `SDM_CTRL_RESET;
      ev_reg <= {`SDM_EV_W{1'b0}};
      ev_en_reg <= {`SDM_EV_W{1'b0}};
      aloss_prev_reg <= 1'b0;
      tloss_prev_reg <= 1'b0;
    end else if (ce) begin
      aloss_prev_reg <= aloss_s;
      tloss_prev_reg <= transition_loss;
      if (wr_en && wr_strb0 && wr_addr == `SDM_OFF_IRQ_CLR)
        ev_reg <= (ev_reg & ~wr_data[`SDM_EV_W-1:0]) | ev_set;
      else
        ev_reg <= ev_reg | ev_set;
      if (wr_en && wr_strb0) begin
        if (wr_addr == `SDM_OFF_CTRL)
          ctrl_reg <= wr_data[7:0];
        else if (wr_addr == `SDM_OFF_IRQ_EN)
          ev_en_reg <= wr_data[`SDM_EV_W-1:0];
      end
    end
  end

  // Read decode
  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    if (rd_addr == `SDM_OFF_CTRL)
      rd_data[7:0] = ctrl_reg;
    else if (rd_addr == `SDM_OFF_STAT)
      rd_data[3:0] = {pll_ref_is_ext, transition_loss, aloss_s, run};
    else if (rd_addr == `SDM_OFF_IRQ_STAT)
      rd_data[`SDM_EV_W-1:0] = ev_reg;
    else if (rd_addr == `SDM_OFF_IRQ_CLR)
      rd_data = 32'h00000000;
    else if (rd_addr == `SDM_OFF_IRQ_EN)
      rd_data[`SDM_EV_W-1:0] = ev_en_reg;
    else if (rd_addr == `SDM_OFF_WORD)
      rd_data[16:0] = {word_parity_out, word_out};
    else
      rd_hit = 1'b0;
  end
endmodule

// ===== sdm_chk.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module sdm_chk (
  input wire aclk,
  input wire aresetn,
  input wire global_reset_n,
  input wire [15:0] word_out,
  input wire [15:0] word_out_n,
  input wire word_parity_out,
  input wire word_parity_out_n,
  input wire word_clock_out,
  input wire word_clock_out_n,
  input wire word_strobe,
  input wire awready,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_data_compl: assert property (word_out_n == ~word_out)
    else $error("data complement wrong");
  chk_parity_even: assert property (word_parity_out == ^word_out &&
    word_parity_out_n == !word_parity_out)
    else $error("parity wrong");
  chk_wclk_compl: assert property (word_clock_out_n == !word_clock_out)
    else $error("word clock complement wrong");
  // Sync latency is two edges, so three low samples must clear the path
  chk_gr_clear: assert property (!global_reset_n [*3] |=>
    word_out == 16'h0000 && !word_clock_out)
    else $error("word path not cleared");
  // Sixteen bits per word, so strobes are far apart
  chk_strobe_gap: assert property (word_strobe |=> !word_strobe [*8])
    else $error("word strobe too soon");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer unstable");
  chk_w_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answering");
  chk_ar_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while answering");
  cov_word: cover property (word_strobe);
  cov_write: cover property (bvalid && bready);
  cov_read: cover property (rvalid && rready);
  cov_greset: cover property (!global_reset_n [*3]);
endmodule
bind sdm_top sdm_chk u_chk (.*);

// ===== sdm_framer.sv
`timescale 1ns/1ps
// ****
// Downstream framer model
// ****
module sdm_framer (
  input wire aclk,
  input wire ref_on,
  input wire [15:0] word_out,
  input wire word_parity_out,
  input wire word_strobe,
  output logic ext_ref_clock,
  output logic [15:0] last_word,
  output logic last_par,
  output int word_cnt
);
  // Reference runs at the standard word rate only while supplied
  initial begin
    ext_ref_clock = 1'b0;
    forever #3.215 ext_ref_clock = ref_on & ~ext_ref_clock;
  end
  // Each strobe hands one whole word over; the int count starts at zero
  always @(posedge aclk) begin
    if (word_strobe) begin
      last_word <= word_out;
      last_par <= word_parity_out;
      word_cnt <= word_cnt + 1;
    end
  end
endmodule

// ===== test_serial_to_parallel_demux_controls.sv
`timescale 1ns/1ps
`include "sdm_regs.vh"
// ****
// Bench
// ****
module test_serial_to_parallel_demux_controls;
  logic aclk, aresetn, ce, global_reset_n, serial_bit, serial_bit_valid;
  logic amp_serial_in, logic_serial_in, serial_src_logic, ref_on;
  logic analog_signal_loss, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [3:0] wstrb;
  logic [1:0] rr;
  logic [15:0] w, fr_word;
  logic fr_par;
  int fr_cnt, bad_count, tests_run, n, c0, c1, ck_hi, sd_hi, bc_hi;
  wire [15:0] word_out, word_out_n;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire word_out_oe, word_parity_out, word_parity_out_n, word_clock_out;
  wire word_clock_out_n, word_strobe, serial_data_out, serial_data_oe;
  wire bit_clock_out, bit_clock_oe, pll_ref_is_ext, transition_loss;
  wire awready, wready, bvalid, arready, rvalid, irq, ext_ref_clock;
  sdm_top dut (.*);
  sdm_framer fr (
    .aclk(aclk),
    .ref_on(ref_on),
    .word_out(word_out),
    .word_parity_out(word_parity_out),
    .word_strobe(word_strobe),
    .ext_ref_clock(ext_ref_clock),
    .last_word(fr_word),
    .last_par(fr_par),
    .word_cnt(fr_cnt)
  );
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // High-cycle counters, zero at start as ints; muting must keep the word clock and serial data counts still
  always @(posedge aclk) begin
    ck_hi <= ck_hi + word_clock_out;
    sd_hi <= sd_hi + serial_data_out;
    bc_hi <= bc_hi + bit_clock_out;
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Each channel is released at its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", bresp, 2'h0);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // Random idle gaps carry the inverted bit so stale data shows
  task automatic send(input logic [15:0] d);
    logic v;
    for (int i = 15; i >= 0; ) begin
      @(posedge aclk);
      v = ($urandom_range(0, 3) != 0);
      serial_bit <= v ? d[i] : ~d[i];
      serial_bit_valid <= v;
      if (v) i--;
    end
    @(posedge aclk);
    serial_bit_valid <= 1'b0;
  endtask
  task automatic word_chk(input logic [15:0] d, input logic [15:0] e);
    int c;
    c = fr_cnt;
    send(d);
    n = 0;
    while (fr_cnt == c && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk("strobes", fr_cnt - c, 1);
    chk("word", fr_word, e);
    chk("parity", fr_par, ^e);
  endtask
  // Pin reset passes a two-stage sync, so wait it out on both edges
  task automatic greset();
    global_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("rst", {word_out, word_out_n}, 32'h0000FFFF);
    global_reset_n <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wait_hi(input int sel);
    n = 0;
    while (!(sel ? irq : pll_ref_is_ext) && n < 20) begin
      @(posedge aclk);
      n++;
    end
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {aresetn, serial_bit, serial_bit_valid, ref_on} = 4'h0;
    {amp_serial_in, logic_serial_in, serial_src_logic} = 3'h0;
    {analog_signal_loss, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {ce, global_reset_n} = 2'h3;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hF};
    {bad_count, tests_run} = 0;
    rd = $urandom(32'h7480FD43);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`SDM_OFF_CTRL);
    chk("ctrl", rd, 32'hF);
    axr(8'h1C);
    chk("rresp", rr, 2'h2);
    // Stray bits, then a word-path reset must realign the count
    serial_bit <= 1'b1;
    serial_bit_valid <= 1'b1;
    repeat (5) @(posedge aclk);
    serial_bit_valid <= 1'b0;
    greset();
    c0 = ck_hi;
    for (int k = 0; k < 8; k++) begin
      w = k == 0 ? 16'h8000 : k == 1 ? 16'h0001 : 16'($urandom);
      word_chk(w, w);
    end
    chk("wclk", ck_hi > c0, 1'b1);
    // Word-path reset, then data mute must turn a live word into zeros
    greset();
    axw(`SDM_OFF_CTRL, 32'hD);
    word_chk(16'hFFFF, 16'h0000);
    axw(`SDM_OFF_CTRL, 32'hB);
    // Let the mute reach the pin before counting high cycles
    @(posedge aclk);
    c0 = ck_hi;
    word_chk(16'h5A5A, 16'h5A5A);
    chk("wclk_mute", ck_hi - c0, 0);
    axw(`SDM_OFF_CTRL, 32'hE);
    chk("oe_off", word_out_oe, 1'b0);
    ref_on <= 1'b1;
    axw(`SDM_OFF_CTRL, 32'h7);
    wait_hi(0);
    chk("ref_ext", pll_ref_is_ext, 1'b1);
    axw(`SDM_OFF_CTRL, 32'h3F);
    chk("ref_int", pll_ref_is_ext, 1'b0);
    chk("hs_oe", {serial_data_oe, bit_clock_oe}, 2'h3);
    axw(`SDM_OFF_CTRL, 32'h4F);
    chk("hs_off", {serial_data_oe, bit_clock_oe}, 2'h0);
    c0 = sd_hi;
    c1 = bc_hi;
    word_chk(16'hFFFF, 16'hFFFF);
    chk("sd_mute", sd_hi - c0, 0);
    chk("bit_clk", bc_hi - c1, 16);
    // Clock enable low must freeze the word path
    c0 = fr_cnt;
    ce <= 1'b0;
    send(16'h1234);
    ce <= 1'b1;
    chk("ce_hold", fr_cnt - c0, 0);
    // Loss events raise, mask and clear the interrupt
    axw(`SDM_OFF_IRQ_CLR, 32'h7);
    axw(`SDM_OFF_IRQ_EN, 32'h2);
    analog_signal_loss <= 1'b1;
    wait_hi(1);
    chk("irq", irq, 1'b1);
    axr(`SDM_OFF_STAT);
    chk("aloss", rd[2:1], 2'h1);
    axw(`SDM_OFF_IRQ_EN, 32'h0);
    chk("irq_mask", irq, 1'b0);
    analog_signal_loss <= 1'b0;
    axw(`SDM_OFF_IRQ_CLR, 32'h7);
    axw(`SDM_OFF_IRQ_EN, 32'h4);
    axr(`SDM_OFF_IRQ_STAT);
    chk("stat_clr", rd[2:1], 2'h0);
    repeat (5) send(16'h0000);
    chk("tloss", {transition_loss, irq}, 2'h3);
    final_report();
  end
endmodule
